// ---- verilog/btx_exec.sv ----
// Execution unit for bit test branch, bit XOR, call and return.
// Assumes stack and program memories on the same clock with combinational
// read of the registered address.
`timescale 1ns/100ps
module btx_exec
	import btx_pkg::*;
(
	// Clock and reset.
	input wire logic i_clock,
	input wire logic i_arst_n,
	// Avalon-MM slave.
	input wire logic [7:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// Stack memory.
	output btx_stk_req_t o_stk,
	input wire logic [7:0] i_stk_rdata,
	// Program memory read port.
	output logic [15:0] o_pmem_addr,
	input wire logic [7:0] i_pmem_data,
	// State.
	output logic o_busy
);

	// ****************************************************************
	// Functions.
	// ****************************************************************
	function automatic logic [3:0] op_cycles(input logic [7:0] op);
		case (op)
			OP_BIT_TEST_BRANCH_IF_SET: op_cycles = CYC_BRANCH;
			OP_BIT_EXCLUSIVE_OR: op_cycles = CYC_XOR;
			OP_CALL_DIRECT: op_cycles = CYC_CALL_DIRECT;
			OP_CALL_PAIR: op_cycles = CYC_CALL_PAIR;
			OP_CALL_VECTOR: op_cycles = CYC_CALL_VECTOR;
			default: op_cycles = CYC_RETURN;
		endcase
	endfunction

	function automatic logic [15:0] sext8(input logic [7:0] v);
		sext8 = {{8{v[7]}}, v};
	endfunction

	// ****************************************************************
	// Reset synchroniser.
	// ****************************************************************
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ****************************************************************
	// State.
	// ****************************************************************
	btx_state_t state_q;
	btx_state_t state_d;
	btx_instr_t instr_q;
	logic [15:0] pc_q;
	logic [15:0] sp_q;
	logic [7:0] flags_q;
	logic [7:0] wreg_q [16];
	logic [15:0] tgt_q;
	logic [3:0] cnt_q;
	logic done_q;
	logic illegal_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic busy_q;
	btx_stk_req_t stk_q;
	logic [15:0] pmem_q;

	// ****************************************************************
	// Bus decode.
	// ****************************************************************
	wire bus_req = i_read | i_write;
	wire bus_ack = bus_req & ~wait_q;
	wire wr_ack = i_write & bus_ack;
	wire idle = (state_q == BTX_IDLE);
	wire wr_ctrl = wr_ack & (i_address == ADDR_CTRL);
	wire wr_status = wr_ack & (i_address == ADDR_STATUS);
	wire wr_instr = wr_ack & idle & (i_address == ADDR_INSTR);
	wire wr_pc = wr_ack & idle & (i_address == ADDR_PC);
	wire wr_sp = wr_ack & idle & (i_address == ADDR_SP);
	wire wr_flags = wr_ack & idle & (i_address == ADDR_FLAGS);
	wire is_wreg = (i_address[7:6] == ADDR_WREG_BASE[7:6]);
	wire wr_wreg = wr_ack & idle & is_wreg & (i_address[1:0] == 2'h0);
	wire [3:0] wreg_sel = i_address[5:2];
	wire go = wr_ctrl & idle & i_writedata[CTRL_GO_BIT];

	// ****************************************************************
	// Instruction decode.
	// ****************************************************************
	wire [7:0] op = instr_q.opcode;
	wire is_branch = (op == OP_BIT_TEST_BRANCH_IF_SET);
	wire is_xor = (op == OP_BIT_EXCLUSIVE_OR);
	wire is_call_da = (op == OP_CALL_DIRECT);
	wire is_call_rr = (op == OP_CALL_PAIR);
	wire is_call_ia = (op == OP_CALL_VECTOR);
	wire is_call = is_call_da | is_call_rr | is_call_ia;
	wire is_ret = (op == OP_SUBROUTINE_RETURN);
	wire is_legal = is_branch | is_xor | is_call | is_ret;
	wire [3:0] work_idx = instr_q.second[7:4];
	wire [2:0] bit_idx = instr_q.second[3:1];
	wire xor_form = instr_q.second[0];
	wire [3:0] reg_idx = instr_q.third[3:0];
	wire [7:0] work_val = wreg_q[work_idx];
	wire [7:0] reg_val = wreg_q[reg_idx];

	// Return address past the instruction, two or three bytes.
	wire [15:0] ins_len = (is_call_rr | is_call_ia) ? LEN_TWO : LEN_THREE;
	wire [15:0] next_pc = pc_q + ins_len;

	// Branch target from a signed byte offset on the following address.
	wire [15:0] br_tgt = next_pc + sext8(instr_q.third);
	wire br_bit = work_val[bit_idx];

	// Bit XOR result and the register it lands in.
	wire [3:0] xor_idx = xor_form ? reg_idx : work_idx;
	wire [7:0] xor_old = xor_form ? reg_val : work_val;
	wire [2:0] xor_pos = xor_form ? bit_idx : 3'h0;
	wire xor_src = xor_form ? work_val[0] : reg_val[bit_idx];
	wire xor_res = xor_old[xor_pos] ^ xor_src;
	logic [7:0] xor_new;
	always_comb begin
		xor_new = xor_old;
		xor_new[xor_pos] = xor_res;
	end

	// Call target for the direct and pair forms.
	wire [15:0] pair_tgt = {wreg_q[{work_idx[3:1], 1'b0}],
		wreg_q[{work_idx[3:1], 1'b1}]};
	wire [15:0] call_tgt = is_call_da ?
		{instr_q.second, instr_q.third} : pair_tgt;
	wire [15:0] sp_dec = sp_q - 16'h0001;
	wire [15:0] sp_dec2 = sp_q - 16'h0002;
	wire [15:0] sp_inc = sp_q + 16'h0001;
	wire [3:0] last_cnt = op_cycles(op) - 4'h1;
	wire cnt_done = (cnt_q >= last_cnt);
	wire finish = (state_q == BTX_FINISH) & cnt_done;

	// ****************************************************************
	// Sequencer.
	// ****************************************************************
	always_comb begin
		state_d = state_q;
		case (state_q)
			BTX_IDLE: begin
				if (go && is_legal) begin
					if (is_call_ia) begin
						state_d = BTX_FETCH_HI;
					end else if (is_call) begin
						state_d = BTX_PUSH_LO;
					end else if (is_ret) begin
						state_d = BTX_POP_HI;
					end else begin
						state_d = BTX_FINISH;
					end
				end
			end
			BTX_FETCH_HI: state_d = BTX_FETCH_LO;
			BTX_FETCH_LO: state_d = BTX_PUSH_LO;
			BTX_PUSH_LO: state_d = BTX_PUSH_HI;
			BTX_PUSH_HI: state_d = BTX_FINISH;
			BTX_POP_HI: state_d = BTX_POP_LO;
			BTX_POP_LO: state_d = BTX_FINISH;
			BTX_FINISH: begin
				if (cnt_done) begin
					state_d = BTX_IDLE;
				end
			end
			default: state_d = BTX_IDLE;
		endcase
	end

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= BTX_IDLE;
			cnt_q <= 4'h0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= idle ? 4'h0 : cnt_q + 4'h1;
			busy_q <= (state_d != BTX_IDLE);
		end
	end

	// ****************************************************************
	// Memory ports and target capture.
	// ****************************************************************
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			stk_q <= '0;
			pmem_q <= 16'h0000;
			tgt_q <= 16'h0000;
		end else begin
			stk_q.we <= 1'b0;
			case (state_q)
				BTX_IDLE: begin
					pmem_q <= {8'h00, instr_q.second};
					stk_q.addr <= is_ret ? sp_q : sp_dec;
					stk_q.wdata <= next_pc[7:0];
					stk_q.we <= go & is_call & ~is_call_ia;
					tgt_q <= call_tgt;
				end
				BTX_FETCH_HI: begin
					tgt_q[15:8] <= i_pmem_data;
					pmem_q <= pmem_q + 16'h0001;
				end
				BTX_FETCH_LO: begin
					tgt_q[7:0] <= i_pmem_data;
					stk_q.addr <= sp_dec;
					stk_q.wdata <= next_pc[7:0];
					stk_q.we <= 1'b1;
				end
				BTX_PUSH_LO: begin
					stk_q.addr <= sp_dec2;
					stk_q.wdata <= next_pc[15:8];
					stk_q.we <= 1'b1;
				end
				BTX_POP_HI: begin
					tgt_q[15:8] <= i_stk_rdata;
					stk_q.addr <= sp_inc;
				end
				BTX_POP_LO: tgt_q[7:0] <= i_stk_rdata;
				default: stk_q.we <= 1'b0;
			endcase
		end
	end

	// ****************************************************************
	// Architectural registers.
	// ****************************************************************
	wire sp_down = (state_q == BTX_PUSH_LO) | (state_q == BTX_PUSH_HI);
	wire sp_up = (state_q == BTX_POP_HI) | (state_q == BTX_POP_LO);
	wire br_taken = is_branch & br_bit;
	wire [15:0] pc_fin = (is_call | is_ret) ? tgt_q :
		br_taken ? br_tgt : next_pc;

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			pc_q <= PC_RESET;
			sp_q <= SP_RESET;
		end else begin
			if (finish) begin
				pc_q <= pc_fin;
			end else if (wr_pc) begin
				pc_q <= i_writedata[15:0];
			end
			if (sp_down) begin
				sp_q <= sp_dec;
			end else if (sp_up) begin
				sp_q <= sp_inc;
			end else if (wr_sp) begin
				sp_q <= i_writedata[15:0];
			end
		end
	end

	// Only bit XOR touches flags; branch, call and return keep them.
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= FLAGS_RESET;
		end else if (finish && is_xor) begin
			flags_q[FLAG_Z_BIT] <= ~xor_res;
			flags_q[FLAG_S_BIT] <= 1'b0;
		end else if (wr_flags) begin
			flags_q <= i_writedata[7:0];
		end
	end

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 16; i++) begin
				wreg_q[i] <= WREG_RESET;
			end
		end else if (finish && is_xor) begin
			wreg_q[xor_idx] <= xor_new;
		end else if (wr_wreg) begin
			wreg_q[wreg_sel] <= i_writedata[7:0];
		end
	end

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			instr_q <= '0;
		end else if (wr_instr) begin
			instr_q <= i_writedata[23:0];
		end
	end

	// Done sets over a software clear in the same cycle.
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
			illegal_q <= 1'b0;
		end else begin
			if (finish) begin
				done_q <= 1'b1;
			end else if (wr_status && i_writedata[ST_DONE_BIT]) begin
				done_q <= 1'b0;
			end
			if (go && !is_legal) begin
				illegal_q <= 1'b1;
			end else if (wr_status && i_writedata[ST_ILLEGAL_BIT]) begin
				illegal_q <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Read mux and bus answer.
	// ****************************************************************
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (i_address)
			ADDR_STATUS: begin
				rd_mux[ST_BUSY_BIT] = ~idle;
				rd_mux[ST_DONE_BIT] = done_q;
				rd_mux[ST_ILLEGAL_BIT] = illegal_q;
			end
			ADDR_INSTR: rd_mux[23:0] = instr_q;
			ADDR_PC: rd_mux[15:0] = pc_q;
			ADDR_SP: rd_mux[15:0] = sp_q;
			ADDR_FLAGS: rd_mux[7:0] = flags_q;
			default: begin
				if (is_wreg && i_address[1:0] == 2'h0) begin
					rd_mux[7:0] = wreg_q[wreg_sel];
				end
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= ~(bus_req & wait_q);
			rdata_q <= rd_mux;
		end
	end

	assign o_waitrequest = wait_q;
	assign o_readdata = rdata_q;
	assign o_stk = stk_q;
	assign o_pmem_addr = pmem_q;
	assign o_busy = busy_q;

endmodule // btx_exec

// ---- verilog/btx_pkg.sv ----
// Constants, types and register map for the bit test, bit XOR and call unit.
// Assumes a single 125 MHz core clock and an Avalon-MM master on the bus.
//
// Contract
// - Opcode 37: branch when chosen bit set.
// - Bit clear: fall through past the instruction.
// - Displacement is signed eight bits, -128..+127.
// - Bit XOR writes only the chosen destination bit.
// - Bit XOR: zero flag, sign cleared, others kept.
// - Opcode 27, second byte: register, bit, form.
// - Call pushes low byte, then high byte.
// - Pushed address follows the call's own length.
// - Call opcodes F6, F4, D4 with their cycles.
// - Vector call reads high byte at lower address.
// - Call leaves every flag unchanged.
// - Return pops high then low into PC.
package btx_pkg;

	// ****************************************************************
	// Opcodes and cycle counts.
	// ****************************************************************
	localparam logic [7:0] OP_BIT_TEST_BRANCH_IF_SET = 8'h37;
	localparam logic [7:0] OP_BIT_EXCLUSIVE_OR = 8'h27;
	localparam logic [7:0] OP_CALL_DIRECT = 8'hF6;
	localparam logic [7:0] OP_CALL_PAIR = 8'hF4;
	localparam logic [7:0] OP_CALL_VECTOR = 8'hD4;
	localparam logic [7:0] OP_SUBROUTINE_RETURN = 8'hFF;
	localparam logic [3:0] CYC_BRANCH = 4'hA;
	localparam logic [3:0] CYC_XOR = 4'h6;
	localparam logic [3:0] CYC_CALL_DIRECT = 4'hE;
	localparam logic [3:0] CYC_CALL_PAIR = 4'hC;
	localparam logic [3:0] CYC_CALL_VECTOR = 4'hE;
	localparam logic [3:0] CYC_RETURN = 4'h8;
	localparam logic [15:0] LEN_TWO = 16'h0002;
	localparam logic [15:0] LEN_THREE = 16'h0003;

	// ****************************************************************
	// Register map, byte addresses.
	// ****************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_INSTR = 8'h08;
	localparam logic [7:0] ADDR_PC = 8'h0C;
	localparam logic [7:0] ADDR_SP = 8'h10;
	localparam logic [7:0] ADDR_FLAGS = 8'h14;
	localparam logic [7:0] ADDR_WREG_BASE = 8'h40;

	// ****************************************************************
	// Field positions and reset values.
	// ****************************************************************
	localparam int CTRL_GO_BIT = 0;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_ILLEGAL_BIT = 2;
	localparam int FLAG_C_BIT = 7;
	localparam int FLAG_Z_BIT = 6;
	localparam int FLAG_S_BIT = 5;
	localparam int FLAG_V_BIT = 4;
	localparam int FLAG_D_BIT = 3;
	localparam int FLAG_H_BIT = 2;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] SP_RESET = 16'h0000;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] WREG_RESET = 8'h00;

	// ****************************************************************
	// Types.
	// ****************************************************************
	typedef struct packed {
		logic [7:0] third;
		logic [7:0] second;
		logic [7:0] opcode;
	} btx_instr_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
	} btx_stk_req_t;

	typedef enum logic [2:0] {
		BTX_IDLE = 3'h0,
		BTX_FETCH_HI = 3'h1,
		BTX_FETCH_LO = 3'h3,
		BTX_PUSH_LO = 3'h2,
		BTX_PUSH_HI = 3'h6,
		BTX_POP_HI = 3'h7,
		BTX_POP_LO = 3'h5,
		BTX_FINISH = 3'h4
	} btx_state_t;

endpackage

// ---- tb/btx_exec_props.sv ----
// Checker for bus handshake, stack pushes and instruction lengths.
// Assumes it is bound into btx_exec and sees only its ports.
`timescale 1ns/100ps
module btx_exec_props
	import btx_pkg::*;
(
	// Clock and reset.
	input wire logic i_clock,
	input wire logic i_arst_n,
	// Bus and execution.
	input wire logic i_read,
	input wire logic i_write,
	input wire logic o_waitrequest,
	input wire btx_stk_req_t o_stk,
	input wire logic o_busy
);
	// ****
	// Counters of busy cycles and pushes.
	// ****
	logic [4:0] cyc_q;
	logic [4:0] push_q;
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cyc_q <= 5'h00;
			push_q <= 5'h00;
		end else begin
			cyc_q <= o_busy ? cyc_q + 5'h01 : 5'h00;
			push_q <= o_busy ? push_q + {4'h0, o_stk.we} : 5'h00;
		end
	end
	// ****
	// Properties.
	// ****
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	sequence push_pair_s;
		o_stk.we ##1 o_stk.we && o_stk.addr == $past(o_stk.addr) - 16'h0001;
	endsequence
	wait_pulse_a: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("waitrequest low for more than one cycle");
	wait_answer_a: assert property ((i_read || i_write) && o_waitrequest
		|=> !o_waitrequest)
		else $error("request not answered after one wait cycle");
	stk_busy_a: assert property (o_stk.we |-> o_busy)
		else $error("stack write outside an instruction");
	push_pair_a: assert property (o_stk.we && !$past(o_stk.we) |-> push_pair_s)
		else $error("second push not one below the first");
	push_end_a: assert property (o_stk.we && $past(o_stk.we) |=> !o_stk.we)
		else $error("more than two stack writes in a row");
	busy_len_a: assert property ($fell(o_busy) |-> cyc_q inside
		{5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E})
		else $error("instruction length not a legal cycle count");
	busy_min_a: assert property ($rose(o_busy) |-> o_busy[*6])
		else $error("instruction shorter than six cycles");
	push_count_a: assert property ($fell(o_busy) |->
		push_q == ((cyc_q >= 5'h0C) ? 5'h02 : 5'h00))
		else $error("wrong number of stack writes");
endmodule // btx_exec_props

bind btx_exec btx_exec_props chk_u (.i_clock(i_clock), .i_arst_n(i_arst_n),
	.i_read(i_read), .i_write(i_write), .o_waitrequest(o_waitrequest),
	.o_stk(o_stk), .o_busy(o_busy));

// ---- tb/tb.sv ----
// Self-checking bench for the bit test, bit XOR and call unit.
// Assumes the checker is bound in; memories are modelled here.
`timescale 1ns/100ps
module tb;
	import btx_pkg::*;
	logic i_clock = 1'b0;
	logic i_arst_n = 1'b0;
	logic i_read = 1'b0;
	logic i_write = 1'b0;
	logic [7:0] i_address = 8'h00;
	logic [31:0] i_writedata = 32'h0;
	logic [31:0] o_readdata;
	logic o_waitrequest;
	logic o_busy;
	btx_stk_req_t o_stk;
	logic [15:0] o_pmem_addr;
	logic [7:0] smem [0:65535];
	logic [7:0] pmem [0:65535];
	wire logic [7:0] i_stk_rdata = smem[o_stk.addr];
	wire logic [7:0] i_pmem_data = pmem[o_pmem_addr];
	logic [7:0] idle_a [5] = '{ADDR_PC, ADDR_SP, ADDR_FLAGS, ADDR_STATUS, 8'h30};
	logic [7:0] call_ops [3] = '{OP_CALL_DIRECT, OP_CALL_PAIR, OP_CALL_VECTOR};
	int fail_count = 0;
	int checks = 0;
	always #4 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		if (o_stk.we === 1'b1) smem[o_stk.addr] <= o_stk.wdata;
	end
	btx_exec dut_u (.i_clock(i_clock), .i_arst_n(i_arst_n),
		.i_address(i_address), .i_read(i_read), .i_write(i_write),
		.i_writedata(i_writedata), .o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest), .o_stk(o_stk),
		.i_stk_rdata(i_stk_rdata), .o_pmem_addr(o_pmem_addr),
		.i_pmem_data(i_pmem_data), .o_busy(o_busy));
	// ****
	// Bus access, comparison and expectation helpers.
	// ****
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic wr_en, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge i_clock);
		i_write <= wr_en;
		i_read <= ~wr_en;
		i_address <= a;
		i_writedata <= d;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_waitrequest !== 1'b0 && n < 40);
		if (n >= 40) check(32'h1, 32'h0);
		q = o_readdata;
		i_write <= 1'b0;
		i_read <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask
	task automatic exec(input logic [23:0] ins, input logic [15:0] pc);
		logic [31:0] q;
		int n;
		n = 0;
		wr(ADDR_INSTR, {8'h00, ins});
		wr(ADDR_PC, {16'h0, pc});
		wr(ADDR_CTRL, 32'h1);
		do begin
			rd(ADDR_STATUS, q);
			n++;
		end while (q[ST_DONE_BIT] !== 1'b1 && n < 20);
		check(q & 32'h7, 32'h2);
		wr(ADDR_STATUS, 32'h2);
	endtask
	function automatic logic [7:0] wa(logic [3:0] n);
		return ADDR_WREG_BASE + {2'b00, n, 2'b00};
	endfunction
	function automatic logic [15:0] br_pc(logic [15:0] pc, logic [7:0] dp,
		logic tk);
		return pc + LEN_THREE + (tk ? {{8{dp[7]}}, dp} : 16'h0000);
	endfunction
	task conclude;
		$display("Checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_clock);
		fail_count++;
		$display("Error at %0t: timeout", $time);
		conclude();
	end
	// ****
	// Tests.
	// ****
	initial begin
		logic [31:0] q;
		logic [3:0] r, t;
		logic [2:0] b;
		logic [7:0] v, w, fl, op;
		logic [15:0] pc, sp, tg, rt;
		logic z;
		void'($urandom(32'h33d9e547));
		repeat (8) @(posedge i_clock);
		i_arst_n <= 1'b1;
		repeat (3) @(posedge i_clock);
		foreach (idle_a[i]) begin
			rd(idle_a[i], q);
			check(q, 32'h0);
		end
		wr(ADDR_INSTR, 32'h0000_0000);
		wr(ADDR_CTRL, 32'h1);
		rd(ADDR_STATUS, q);
		check(q & 32'h7, 32'h4);
		wr(ADDR_STATUS, 32'h4);
		rd(ADDR_STATUS, q);
		check(q & 32'h7, 32'h0);
		$display("Reset values test done");
		for (int i = 0; i < 10; i++) begin
			r = 4'($urandom);
			b = 3'($urandom);
			v = 8'($urandom);
			v[b] = i[0];
			fl = 8'($urandom) & 8'hFC;
			pc = 16'($urandom);
			w = (i < 2) ? (i == 0 ? 8'h80 : 8'h7F) : 8'($urandom);
			wr(wa(r), {24'h0, v});
			wr(ADDR_FLAGS, {24'h0, fl});
			exec({w, r, b, 1'b1, OP_BIT_TEST_BRANCH_IF_SET}, pc);
			rd(ADDR_PC, q);
			check(q, {16'h0, br_pc(pc, w, v[b])});
			rd(ADDR_FLAGS, q);
			check(q, {24'h0, fl});
		end
		$display("Bit test branch test done");
		for (int i = 0; i < 8; i++) begin
			r = 4'($urandom);
			t = r + 4'h1 + 4'($urandom_range(14, 0));
			b = 3'($urandom);
			v = 8'($urandom);
			w = 8'($urandom);
			fl = 8'($urandom) & 8'hFC;
			wr(wa(r), {24'h0, v});
			wr(wa(t), {24'h0, w});
			wr(ADDR_FLAGS, {24'h0, fl});
			exec({4'h0, t, r, b, i[0], OP_BIT_EXCLUSIVE_OR}, 16'($urandom));
			z = v[0] ^ w[b];
			if (i[0]) w[b] = z;
			else v[0] = z;
			rd(wa(r), q);
			check(q, {24'h0, v});
			rd(wa(t), q);
			check(q, {24'h0, w});
			rd(ADDR_FLAGS, q);
			check(q & 32'hEF, {24'h0, fl[7], ~z, 2'b00, fl[3:2], 2'b00});
		end
		$display("Bit exclusive or test done");
		for (int i = 0; i < 6; i++) begin
			op = call_ops[i % 3];
			pc = 16'($urandom);
			sp = 16'($urandom_range(65535, 2));
			tg = 16'($urandom);
			v = 8'($urandom);
			fl = 8'($urandom) & 8'hFC;
			rt = pc + ((op == OP_CALL_DIRECT) ? LEN_THREE : LEN_TWO);
			if (op == OP_CALL_PAIR) begin
				v[4:0] = 5'h00;
				wr(wa({v[7:5], 1'b0}), {24'h0, tg[15:8]});
				wr(wa({v[7:5], 1'b1}), {24'h0, tg[7:0]});
			end
			pmem[{8'h00, v}] = tg[15:8];
			pmem[{8'h00, v} + 16'h0001] = tg[7:0];
			wr(ADDR_SP, {16'h0, sp});
			wr(ADDR_FLAGS, {24'h0, fl});
			if (op == OP_CALL_DIRECT) exec({tg[7:0], tg[15:8], op}, pc);
			else exec({8'h00, v, op}, pc);
			rd(ADDR_PC, q);
			check(q, {16'h0, tg});
			rd(ADDR_SP, q);
			check(q, {16'h0, sp - 16'h0002});
			check({24'h0, smem[sp - 16'h0001]}, {24'h0, rt[7:0]});
			check({24'h0, smem[sp - 16'h0002]}, {24'h0, rt[15:8]});
			rd(ADDR_FLAGS, q);
			check(q, {24'h0, fl});
			exec({16'h0000, OP_SUBROUTINE_RETURN}, tg);
			rd(ADDR_PC, q);
			check(q, {16'h0, rt});
			rd(ADDR_SP, q);
			check(q, {16'h0, sp});
		end
		$display("Call and return test done");
		conclude();
	end
endmodule // tb
